// File: src/spsc_defines.svh
// constants of the serial port status and control block
// assumes a 100 MHz sys_clk and a word-addressed Avalon-MM slave
`ifndef SPSC_DEFINES_SVH
`define SPSC_DEFINES_SVH

// -------------------------------------------------------------
// register word addresses
// -------------------------------------------------------------
`define SPSC_ADDR_STAT      3'h0
`define SPSC_ADDR_BUF       3'h1
`define SPSC_ADDR_IRQ_STAT  3'h2
`define SPSC_ADDR_IRQ_MASK  3'h3

// -------------------------------------------------------------
// field positions and reset values
// -------------------------------------------------------------
`define SPSC_BIT_ENABLE     15
`define SPSC_BIT_IDLE_STOP  13
`define SPSC_BIT_OVERFLOW   6
`define SPSC_BIT_TX_FULL    1
`define SPSC_BIT_RX_FULL    0
`define SPSC_STAT_RESERVED  16'h5FBC
`define SPSC_STAT_RESET     16'h0000
`define SPSC_IRQ_DONE       0
`define SPSC_IRQ_OVERFLOW   1
`define SPSC_IRQ_RESET      2'h0
`define SPSC_WORD_RESET     16'h0000
`define SPSC_LAST_BIT       4'hF

`endif

// File: src/spsc_pkg.sv
// types of the serial port status and control block
// assumes spsc_defines.svh is not needed here: types only
package spsc_pkg;

  typedef struct packed {
    logic [15:0] sr;
    logic [3:0]  cnt;
    logic        sdo;
  } spsc_shift_state_t;

  typedef struct packed {
    logic [1:0]  sck_s;
    logic [1:0]  sdi_s;
    logic [1:0]  sel_s;
    logic        sck_d;
    logic        enable;
    logic        idle_stop;
    logic        ovf;
    logic        tbf;
    logic        rbf;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        waitrequest;
    logic [31:0] readdata;
    logic        irq;
    logic        sdo_oe;
  } spsc_top_state_t;

endpackage

// File: src/spsc_shifter.sv
// 16-bit slave shift register, msb first, sample on rise, drive on fall
// assumes clock edges arrive already synchronised and qualified
`include "spsc_defines.svh"

module spsc_shifter (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        enable,
  input  wire logic        selected,
  input  wire logic        sck_rise,
  input  wire logic        sck_fall,
  input  wire logic        sdi,
  input  wire logic        tx_valid,
  input  wire logic [15:0] tx_word,
  output logic             tx_taken,
  output logic             done,
  output logic [15:0]      rx_word,
  output logic             sdo
);

  spsc_pkg::spsc_shift_state_t st;
  spsc_pkg::spsc_shift_state_t next_st;

  assign sdo = st.sdo;

  always_comb
  begin
    next_st  = st;
    done     = 1'b0;
    tx_taken = 1'b0;
    rx_word  = {st.sr[14:0], sdi};
    if (!enable || !selected)
    begin
      // deselect aborts a partial word
      next_st.cnt = 4'h0;
    end
    else if (sck_rise)
    begin
      next_st.sr  = rx_word;
      next_st.cnt = st.cnt + 4'h1;
      done        = (st.cnt == `SPSC_LAST_BIT);
    end
    else if (sck_fall)
    begin
      next_st.sdo = st.sr[15];
    end
    // load only between words so a running word is never corrupted
    if (tx_valid && (done || (st.cnt == 4'h0 && !sck_rise)))
    begin
      next_st.sr  = tx_word;
      next_st.sdo = tx_word[15];
      tx_taken    = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st <= '0;
    else
      st <= next_st;
  end

endmodule

// File: src/spsc_top.sv
// serial port status and control: registers, pin sync, shifter, interrupt
// assumes an Avalon-MM master on sys_clk and a slave-mode link whose
// clock is far slower than sys_clk (sampled, not used as a clock)
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`include "spsc_defines.svh"

module spsc_top (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             irq,
  input  wire logic        idle_mode,
  input  wire logic        serial_clock_pin,
  input  wire logic        serial_in_pin,
  input  wire logic        select_pin_n,
  output logic             serial_out_pin,
  output logic             serial_out_oe
);

  spsc_pkg::spsc_top_state_t st;
  spsc_pkg::spsc_top_state_t next_st;

  logic        run;
  logic        sck_rise;
  logic        sck_fall;
  logic        req;
  logic        tx_taken;
  logic        done;
  logic [15:0] rx_word;
  logic [15:0] stat_word;

  assign readdata      = st.readdata;
  assign waitrequest   = st.waitrequest;
  assign irq           = st.irq;
  assign serial_out_oe = st.sdo_oe;

  // -------------------------------------------------------------
  // link qualification
  // -------------------------------------------------------------
  // overflow and idle-stop freeze the port by hiding clock edges
  assign run = st.enable && !(idle_mode && st.idle_stop)
               && !st.ovf;
  assign sck_rise = run && st.sck_s[1] && !st.sck_d;
  assign sck_fall = run && !st.sck_s[1] && st.sck_d;
  assign req      = (read || write) && st.waitrequest;

  assign stat_word = {st.enable, 1'b0, st.idle_stop, 6'h00,
                      st.ovf, 4'h0, st.tbf, st.rbf};

  spsc_shifter u_shifter (
    .clk      (sys_clk),
    .reset_n  (reset_n),
    .enable   (st.enable),
    .selected (!st.sel_s[1]),
    .sck_rise (sck_rise),
    .sck_fall (sck_fall),
    .sdi      (st.sdi_s[1]),
    .tx_valid (st.tbf),
    .tx_word  (st.tx),
    .tx_taken (tx_taken),
    .done     (done),
    .rx_word  (rx_word),
    .sdo      (serial_out_pin)
  );

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    next_st       = st;
    next_st.sck_s = {st.sck_s[0], serial_clock_pin};
    next_st.sdi_s = {st.sdi_s[0], serial_in_pin};
    next_st.sel_s = {st.sel_s[0], select_pin_n};
    next_st.sck_d = st.sck_s[1];
    next_st.sdo_oe = st.enable && !st.sel_s[1];
    // one wait cycle, then a single ready cycle per request
    next_st.waitrequest = !req;

    // bus side: clears first, so hardware sets below win
    if (req && read)
    begin
      unique case (address)
        `SPSC_ADDR_STAT:
          next_st.readdata = {16'h0000, stat_word};
        `SPSC_ADDR_BUF:
        begin
          next_st.readdata = {16'h0000, st.rx};
          next_st.rbf      = 1'b0;
        end
        `SPSC_ADDR_IRQ_STAT:
          next_st.readdata = {30'h0, st.irq_stat};
        `SPSC_ADDR_IRQ_MASK:
          next_st.readdata = {30'h0, st.irq_mask};
        default:
          next_st.readdata = 32'h0000_0000;
      endcase
    end
    if (req && write)
    begin
      unique case (address)
        `SPSC_ADDR_STAT:
        begin
          if (byteenable[1])
          begin
            next_st.enable    = writedata[`SPSC_BIT_ENABLE];
            next_st.idle_stop = writedata[`SPSC_BIT_IDLE_STOP];
          end
          if (byteenable[0] && !writedata[`SPSC_BIT_OVERFLOW])
            next_st.ovf = 1'b0;
        end
        `SPSC_ADDR_BUF:
        begin
          if (byteenable[0])
            next_st.tx[7:0] = writedata[7:0];
          if (byteenable[1])
            next_st.tx[15:8] = writedata[15:8];
          next_st.tbf = 1'b1;
        end
        `SPSC_ADDR_IRQ_STAT:
          if (byteenable[0])
            next_st.irq_stat = st.irq_stat & ~writedata[1:0];
        `SPSC_ADDR_IRQ_MASK:
          if (byteenable[0])
            next_st.irq_mask = writedata[1:0];
        default:
          next_st.irq_mask = st.irq_mask;
      endcase
    end

    // hardware side
    // a write landing with the load keeps the new word pending
    if (tx_taken && !(req && write && address == `SPSC_ADDR_BUF))
      next_st.tbf = 1'b0;
    if (done)
    begin
      next_st.irq_stat[`SPSC_IRQ_DONE] = 1'b1;
      if (st.rbf)
      begin
        // new word is lost, buffer keeps the unread one
        next_st.ovf = 1'b1;
        next_st.irq_stat[`SPSC_IRQ_OVERFLOW] = 1'b1;
      end
      else
      begin
        next_st.rx  = rx_word;
        next_st.rbf = 1'b1;
      end
    end
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st             <= '0;
      st.sel_s       <= 2'h3;
      st.waitrequest <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  enable_pins_a: assert property (
    !st.enable |=> !serial_out_oe ##1 !serial_out_oe || st.enable)
    else $error("pin driven while port disabled");
  idle_halt_a: assert property (
    idle_mode && st.idle_stop && st.enable |-> !sck_rise && !sck_fall)
    else $error("port ran while idle-stopped");
  idle_run_a: assert property (
    st.enable && !st.idle_stop && !st.ovf && st.sck_s[1] && !st.sck_d
    |-> sck_rise)
    else $error("edge lost while running in idle");
  reserved_zero_a: assert property (
    req && read && address == `SPSC_ADDR_STAT
    |=> (readdata[15:0] & `SPSC_STAT_RESERVED) == 16'h0000)
    else $error("reserved status bit read as one");
  rx_set_a: assert property (
    done && !st.rbf |=> st.rbf && st.rx == $past(rx_word))
    else $error("received word not stored");
  rx_clear_a: assert property (
    req && read && address == `SPSC_ADDR_BUF && !done |=> !st.rbf)
    else $error("receive-full not cleared by read");
  overflow_drop_a: assert property (
    done && st.rbf |=> st.ovf && $stable(st.rx)
    && (st.rbf || $past(req && read && address == `SPSC_ADDR_BUF)))
    else $error("overflow not flagged or buffer changed");
  overflow_freeze_a: assert property (
    st.ovf |-> !sck_rise && !sck_fall)
    else $error("clock edge seen during overflow");
  tx_load_a: assert property (
    done && st.tbf && !(req && write) |=> !st.tbf)
    else $error("pending transmit word not loaded");
  bus_answer_a: assert property (
    req |=> !waitrequest ##1 waitrequest)
    else $error("bad waitrequest answer");

  word_done_c: cover property (done && st.tbf);
  overflow_c: cover property (done && st.rbf);
  buf_read_c: cover property (req && read && address == `SPSC_ADDR_BUF
                              && st.rbf);

endmodule

// File: testbench/spsc_link_master.sv
// link master model: makes the link clock, data and select
// assumes a slave that samples on the rising clock, msb first
module spsc_link_master (
  output logic      serial_clock_pin,
  output logic      serial_in_pin,
  output logic      select_pin_n,
  input  wire logic serial_out_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    serial_clock_pin = 1'b0;
    serial_in_pin    = 1'b0;
    select_pin_n     = 1'b1;
  end

  // clock stands low between frames; released data line is inverted
  // so a stale bit is never mistaken for a driven one
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    select_pin_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      serial_in_pin = tx[i];
      #80 serial_clock_pin = 1'b1;
      rx[i] = serial_out_pin;
      #80 serial_clock_pin = 1'b0;
    end
    #80 select_pin_n = 1'b1;
    serial_in_pin = ~serial_in_pin;
    #160;
  endtask
endmodule

// File: testbench/tb_serial_port_status_control.sv
// self-checking bench of the serial port status and control block
// assumes spsc_top and the link master model are compiled first
module tb_serial_port_status_control;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        wr;
    logic [2:0]  addr;
    logic [31:0] data;
    logic [31:0] exp;
  } spsc_row_t;

  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  address = 3'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic        idle_mode = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] q;
  logic        waitrequest, irq, sck, sdi, sel_n, sdo, sdo_oe;
  logic [15:0] rx;
  int          fail_count = 0;
  int          n_tests = 0;
  spsc_row_t   rows [7];

  always #5 sys_clk = ~sys_clk;

  spsc_top spsc_top_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .idle_mode(idle_mode),
    .serial_clock_pin(sck), .serial_in_pin(sdi), .select_pin_n(sel_n),
    .serial_out_pin(sdo), .serial_out_oe(sdo_oe));

  spsc_link_master spsc_link_master_inst (.serial_clock_pin(sck),
    .serial_in_pin(sdi), .select_pin_n(sel_n), .serial_out_pin(sdo));

  // ---------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------
  task automatic final_report();
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    address   <= a;
    writedata <= d;
    write     <= wr;
    read      <= !wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    r = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      final_report();
    end
  endtask

  task automatic rd(input logic [2:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic xf(input logic [15:0] w);
    spsc_link_master_inst.xfer(w, rx);
  endtask

  initial
  begin
    #200000;
    fail_count++;
    final_report();
  end

  // ---------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------
  initial
  begin
    rows = '{
      '{1'b0, 3'h0, 32'h0, 32'h0},
      '{1'b1, 3'h0, 32'hFFFF, 32'h0},
      '{1'b0, 3'h0, 32'h0, 32'hA000},
      '{1'b1, 3'h3, 32'h1, 32'h0},
      '{1'b0, 3'h3, 32'h0, 32'h1},
      '{1'b0, 3'h5, 32'h0, 32'h0},
      '{1'b1, 3'h0, 32'h8000, 32'h0}};
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    foreach (rows[i])
    begin
      bus(rows[i].wr, rows[i].addr, rows[i].data, q);
      if (!rows[i].wr)
        chk(q, rows[i].exp);
    end
    bus(1'b1, 3'h1, 32'h1234, q);
    rd(3'h0, 32'h8000);
    xf(16'hA5C3);
    chk({16'h0, rx}, 32'h1234);
    chk({31'h0, irq}, 32'h1);
    rd(3'h0, 32'h8001);
    rd(3'h1, 32'hA5C3);
    rd(3'h0, 32'h8000);
    bus(1'b1, 3'h2, 32'h1, q);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    // second word lands on a full buffer and is dropped
    xf(16'h1111);
    xf(16'h2222);
    rd(3'h0, 32'h8041);
    rd(3'h2, 32'h3);
    rd(3'h1, 32'h1111);
    xf(16'h3333);
    rd(3'h0, 32'h8040);
    bus(1'b1, 3'h0, 32'h8000, q);
    rd(3'h0, 32'h8000);
    bus(1'b1, 3'h0, 32'hA000, q);
    idle_mode <= 1'b1;
    xf(16'h4444);
    rd(3'h0, 32'hA000);
    bus(1'b1, 3'h0, 32'h8000, q);
    xf(16'h5555);
    rd(3'h1, 32'h5555);
    idle_mode <= 1'b0;
    // word written mid-frame waits with transmit-full set until word end
    fork
      xf(16'h7777);
      begin
        repeat (40) @(posedge sys_clk);
        bus(1'b1, 3'h1, 32'hBEEF, q);
        rd(3'h0, 32'h8002);
        chk({31'h0, sdo_oe}, 32'h1);
      end
    join
    chk({16'h0, rx}, 32'h5555);
    rd(3'h0, 32'h8001);
    rd(3'h1, 32'h7777);
    xf(16'h0000);
    chk({16'h0, rx}, 32'hBEEF);
    rd(3'h1, 32'h0000);
    bus(1'b1, 3'h0, 32'h0, q);
    xf(16'h6666);
    rd(3'h0, 32'h0);
    chk({31'h0, sdo_oe}, 32'h0);
    bus(1'b1, 3'h0, 32'h8000, q);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({30'h0, waitrequest, irq}, 32'h2);
    reset_n <= 1'b1;
    rd(3'h0, 32'h0);
    final_report();
  end
endmodule
